// ### src/vdop_defs.svh
/*
 * Register map, field positions, reset values and counts of the video
 * output port. Assumes inclusion by vdop_pkg and vdop_top only.
 */
`ifndef VDOP_DEFS_SVH
`define VDOP_DEFS_SVH
// register word indices (address bits 4:2)
`define VDOP_A_TC 3'h0
`define VDOP_A_POL 3'h1
`define VDOP_A_FMT 3'h2
`define VDOP_A_HWIN 3'h3
`define VDOP_A_VWIN 3'h4
`define VDOP_A_GEOM 3'h5
`define VDOP_A_SPIO 3'h6
`define VDOP_A_STAT 3'h7
// timing control fields
`define VDOP_TC_UNIT 0
`define VDOP_TC_HONLY 1
`define VDOP_TC_BUS8 2
`define VDOP_TC_MODE2 3
`define VDOP_TC_QACT 4
`define VDOP_TC_SLEEP 5
`define VDOP_TC_REL 6
`define VDOP_TC_MASK 32'h0000_003F
`define VDOP_POL_MASK 32'h0000_007F
`define VDOP_FMT_MASK 32'h0000_000F
`define VDOP_WIN_MASK 32'h03FF_03FF
`define VDOP_SPIO_MASK 32'h0000_FFFF
// output format fields
`define VDOP_FMT_CCDIS 3
// reset values
`define VDOP_HWIN_RST 32'h0340_0080
`define VDOP_VWIN_RST 32'h01E0_0028
`define VDOP_GEOM_RST 32'h020D_038E
// counts
`define VDOP_LP_WIDTH 64
`define VDOP_FP_LINES 6
`define VDOP_CC_HALF 8
`define VDOP_CODE_LEN 4
`define VDOP_CODE_FF 8'hFF
`define VDOP_CODE_00 8'h00
`endif

// ### src/vdop_pkg.sv
/*
 * Types shared by the video output port.
 * Assumes vdop_defs.svh is on the include path.
 */
`include "vdop_defs.svh"
package vdop_pkg;
  typedef logic [9:0] vdop_cnt_t;
  typedef logic [31:0] vdop_word_t;
  typedef enum logic {VDOP_WR_IDLE, VDOP_WR_RESP} vdop_wr_t;
endpackage

// ### src/vdop_top.sv
/*
 * Video decoder output port: timing markers, qualified clock, pixel bus,
 * three-state control, caption status and an AXI4-Lite register slave.
 * Assumes sys_clk is twice the 2x pixel clock, pixel data and caption level
 * come from logic on sys_clk, and pins pass through two flip-flops.
 */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
// Overview of operation
// - line start pulse is 64 1x cycles; its rising edge starts a line
// - width unit bit counts the line pulse in pixels instead of cycles
// - field pulse changes on 1x rise, six lines wide, rise starts field
// - each marker output is inverted by its polarity register bit
// - active high in viewable region, composite or horizontal, bounds set
// - qualified clock rises only with valid active pixel data on the bus
// - qualified clock runs inverted to the 1x, or 2x in 8-bit, clock
// - in mode 2 qualified clock edges are held off during control codes
// - outputs except caption status and 8-bit spare lines float while enable is high; drive two sys_clk rises after it goes low
// - output group disable bits float pin subgroups individually
// - field parity high for odd fields, before polarity inversion
// - chroma flag high while presented chroma byte is Cb
// - 16-bit uses whole bus from bit 0; 8-bit uses upper byte only
// - bus updates on 1x clock in 16-bit mode, 2x clock in 8-bit mode
// - mode 2 interleaves embedded control codes with pixel data
// - in 8-bit mode lower eight lines are spare general purpose I/O
// - pixel valid only on cycles carrying a valid scaled pixel
// - open-drain caption status pulls low at 8 characters, disableable
// - power-down pin high acts as the clock sleep bit
// - vertical window drops vertical_delay_count/2 lines after field pulse, rises later
// - strap caught at reset keeps outputs floating when high
// - crystal count pin picks the default crystal for auto detection
`timescale 1ns/100ps
`default_nettype none
`include "vdop_defs.svh"
module vdop_top #(
  parameter int AW = 8,
  parameter int LP_WIDTH = `VDOP_LP_WIDTH,
  parameter int FP_LINES = `VDOP_FP_LINES,
  parameter int CC_HALF = `VDOP_CC_HALF
) (
  input wire logic sys_clk, // twice the 2x pixel clock, 10 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic [AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte lanes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output vdop_pkg::vdop_word_t s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [7:0] pix_luma, // scaled luma
  input wire logic [7:0] pix_chroma, // scaled chroma, Cb/Cr alternating
  input wire logic pix_ok, // scaled pixel present this 1x cycle
  input wire logic [4:0] caption_level, // caption fifo fill
  input wire logic output_enable_n, // pin, active low
  input wire logic power_down_input, // pin, high = sleep
  input wire logic tristate_at_reset_select, // strap pin
  input wire logic crystal_count_select, // pin, high = two crystals
  output logic line_start_pulse, // line marker
  output logic field_start_pulse, // field marker
  output logic active, // active window marker
  output logic field_parity, // odd field marker
  output logic chroma_phase_flag, // Cb byte marker
  output logic pixel_valid, // pixel present marker
  output logic vertical_window, // vertical blanking marker
  output logic marker_oe_n, // markers enable, low drives
  output logic qualified_pixel_clock, // gated pixel clock
  output logic pixel_clock_1x, // 1x clock out
  output logic pixel_clock_2x, // 2x clock out
  output logic clock_oe_n, // clock pins enable, low drives
  output logic [15:0] video_data_bus, // pixel bus out
  input wire logic [7:0] video_data_bus_in, // lower lines in
  output logic [15:0] video_data_bus_oe_n, // per line, low drives
  output logic caption_fifo_half_full_n, // open drain, always 0
  output logic caption_fifo_half_full_n_oe_n, // low pulls pin low
  output logic power_down, // block asleep
  output logic crystal_default_secondary // auto-detect default
);
  import vdop_pkg::*;

  localparam int NS = 12;

  function automatic vdop_word_t strb(vdop_word_t o, vdop_word_t n,
                                      logic [3:0] s);
    vdop_word_t r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(logic [AW-1:0] a);
    return a[AW-1:5] == '0 && a[1:0] == 2'b00;
  endfunction

  generate
    if (AW < 6 || LP_WIDTH < 1 || LP_WIDTH > 127 || FP_LINES < 1 ||
        CC_HALF < 1 || CC_HALF > 31) begin : g_bad
      $error("vdop_top: unsupported parameter value");
    end
  endgenerate

  // pin synchronisers
  logic [NS-1:0] sync1, sync2;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {video_data_bus_in, crystal_count_select,
                tristate_at_reset_select, power_down_input, output_enable_n};
      sync2 <= sync1;
    end
  end
  wire logic oe_s = sync2[0];
  wire logic pd_s = sync2[1];
  wire logic strap_s = sync2[2];
  wire logic xtal_s = sync2[3];
  wire logic [7:0] gpio_s = sync2[11:4];

  // registers
  vdop_word_t tc, pol, fmt, hwin, vwin, geom, spio;
  vdop_wr_t wst;
  logic aw_got, w_got, wr_fire, rel;
  logic [AW-1:0] awaddr_q;
  vdop_word_t wdata_q;
  logic [3:0] wstrb_q;
  assign s_axi_awready = !aw_got && wst == VDOP_WR_IDLE;
  assign s_axi_wready = !w_got && wst == VDOP_WR_IDLE;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = wst == VDOP_WR_IDLE && aw_got && w_got;
  assign rel = wr_fire && awaddr_q[4:2] == `VDOP_A_TC &&
               wstrb_q[0] && wdata_q[`VDOP_TC_REL];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wst <= VDOP_WR_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      unique case (wst)
        VDOP_WR_IDLE: begin
          if (wr_fire) begin
            wst <= VDOP_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_q) ? 2'b00 : 2'b10;
          end
        end
        VDOP_WR_RESP: begin
          if (s_axi_bready) begin
            wst <= VDOP_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tc <= '0;
      pol <= '0;
      fmt <= '0;
      hwin <= `VDOP_HWIN_RST;
      vwin <= `VDOP_VWIN_RST;
      geom <= `VDOP_GEOM_RST;
      spio <= '0;
    end else if (wr_fire && mapped(awaddr_q)) begin
      unique case (awaddr_q[4:2])
        `VDOP_A_TC: tc <= strb(tc, wdata_q, wstrb_q) & `VDOP_TC_MASK;
        `VDOP_A_POL: pol <= strb(pol, wdata_q, wstrb_q) & `VDOP_POL_MASK;
        `VDOP_A_FMT: fmt <= strb(fmt, wdata_q, wstrb_q) & `VDOP_FMT_MASK;
        `VDOP_A_HWIN: hwin <= strb(hwin, wdata_q, wstrb_q) & `VDOP_WIN_MASK;
        `VDOP_A_VWIN: vwin <= strb(vwin, wdata_q, wstrb_q) & `VDOP_WIN_MASK;
        `VDOP_A_GEOM: geom <= strb(geom, wdata_q, wstrb_q) & `VDOP_WIN_MASK;
        `VDOP_A_SPIO: spio <= strb(spio, wdata_q, wstrb_q) & `VDOP_SPIO_MASK;
        `VDOP_A_STAT: spio <= spio;
      endcase
    end
  end

  // strap capture and three-state hold
  logic [1:0] init_cnt;
  logic tri_hold;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt <= 2'd0;
      tri_hold <= 1'b1;
    end else begin
      if (init_cnt != 2'd3) begin
        init_cnt <= init_cnt + 2'd1;
      end
      if (init_cnt == 2'd2) begin
        tri_hold <= strap_s;
      end else if (rel) begin
        tri_hold <= 1'b0;
      end
    end
  end

  // clock phases: 2x = ~ph[0], 1x = ph[1]
  logic [1:0] ph;
  wire logic [1:0] next_ph = ph + 2'd1;
  wire logic tick2 = ph[0];
  wire logic tick1 = ph == 2'd1;
  wire logic bus8 = tc[`VDOP_TC_BUS8];
  wire logic mode2 = tc[`VDOP_TC_MODE2];
  assign power_down = pd_s || tc[`VDOP_TC_SLEEP];
  assign crystal_default_secondary = xtal_s;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 2'd0;
      pixel_clock_1x <= 1'b0;
      pixel_clock_2x <= 1'b1;
    end else begin
      ph <= next_ph;
      pixel_clock_1x <= next_ph[1];
      pixel_clock_2x <= !next_ph[0];
    end
  end

  // raster timing, advanced on each 1x rise while not powered down
  vdop_cnt_t hcnt, vcnt;
  logic [6:0] lp_cnt;
  logic lp_raw, odd;
  wire logic adv = tick1 && !power_down;
  wire vdop_cnt_t hs = hwin[9:0];
  wire vdop_cnt_t he = hwin[25:16];
  wire vdop_cnt_t vb = {1'b0, vwin[9:1]};
  wire vdop_cnt_t ve = vb + {1'b0, vwin[25:17]};
  wire logic fp_raw = vcnt < vdop_cnt_t'(FP_LINES);
  wire logic vblank = !(vcnt >= vb && vcnt < ve);
  wire logic hact = hcnt >= hs && hcnt < he;
  wire logic act_raw = tc[`VDOP_TC_HONLY] ? hact : hact && !vblank;
  wire logic code_on = mode2 && hs >= vdop_cnt_t'(`VDOP_CODE_LEN) &&
                       hcnt >= hs - vdop_cnt_t'(`VDOP_CODE_LEN) &&
                       hcnt < hs;
  wire logic lp_step = !tc[`VDOP_TC_UNIT] || pix_ok;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hcnt <= '0;
      vcnt <= '0;
      lp_cnt <= '0;
      lp_raw <= 1'b0;
      odd <= 1'b1;
    end else if (adv) begin
      if (hcnt >= geom[9:0] - 10'd1) begin
        hcnt <= '0;
        lp_raw <= 1'b1;
        lp_cnt <= '0;
        if (vcnt >= geom[25:16] - 10'd1) begin
          vcnt <= '0;
          odd <= !odd;
        end else begin
          vcnt <= vcnt + 10'd1;
        end
      end else begin
        hcnt <= hcnt + 10'd1;
        if (lp_raw && lp_step) begin
          lp_cnt <= lp_cnt + 7'd1;
          if (lp_cnt == 7'(LP_WIDTH - 1)) begin
            lp_raw <= 1'b0;
          end
        end
      end
    end
  end

  // pixel capture and chroma phase
  logic [7:0] luma_q, chroma_q;
  logic valid_q, cb_q, code_q, act_q, vb_q;
  logic [1:0] code_idx;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      luma_q <= '0;
      chroma_q <= '0;
      valid_q <= 1'b0;
      cb_q <= 1'b1;
      code_q <= 1'b0;
      act_q <= 1'b0;
      vb_q <= 1'b1;
      code_idx <= 2'd0;
    end else if (adv) begin
      luma_q <= pix_luma;
      chroma_q <= pix_chroma;
      valid_q <= pix_ok && !code_on;
      code_q <= code_on;
      act_q <= act_raw;
      vb_q <= vblank;
      code_idx <= 2'(hcnt - (hs - vdop_cnt_t'(`VDOP_CODE_LEN)));
      if (hcnt == '0) begin
        cb_q <= 1'b1;
      end else if (pix_ok) begin
        cb_q <= !cb_q;
      end
    end
  end

  // embedded code byte: ff 00 00 then status
  logic [7:0] code_byte;
  always_comb begin
    unique case (code_idx)
      2'd0: code_byte = `VDOP_CODE_FF;
      2'd1: code_byte = `VDOP_CODE_00;
      2'd2: code_byte = `VDOP_CODE_00;
      2'd3: code_byte = {1'b1, !odd, vb_q, 5'b0_0000};
    endcase
  end

  // data bus: 1x updates in 16-bit, 2x updates in 8-bit
  wire logic [7:0] hi_d = code_q ? code_byte : ph == 2'd1 ? chroma_q : luma_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      video_data_bus <= '0;
    end else begin
      if (bus8 && tick2) begin
        video_data_bus <= {hi_d, spio[7:0]};
      end else if (!bus8 && ph == 2'd2) begin
        video_data_bus <= code_q ? {code_byte, code_byte}
                                 : {luma_q, chroma_q};
      end
    end
  end

  // qualified clock: gate moves only while its source is high
  logic gate;
  wire logic src = bus8 ? !next_ph[0] : next_ph[1];
  wire logic next_gate = valid_q && !code_q &&
                         (!tc[`VDOP_TC_QACT] || act_q);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate <= 1'b0;
      qualified_pixel_clock <= 1'b0;
    end else begin
      if (src) begin
        gate <= next_gate;
      end
      qualified_pixel_clock <= !src && (src ? next_gate : gate);
    end
  end

  // markers with polarity
  wire logic [6:0] raw = {vblank, valid_q, cb_q, odd, act_q, fp_raw, lp_raw};
  logic [6:0] mk;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mk <= '0;
    end else begin
      mk <= raw ^ pol[6:0];
    end
  end
  assign {vertical_window, pixel_valid, chroma_phase_flag, field_parity,
          active, field_start_pulse, line_start_pulse} = mk;

  // output enables
  wire logic off = oe_s || tri_hold;
  logic [15:0] bus_oe_n;
  always_comb begin
    bus_oe_n = {16{off || fmt[0]}};
    if (bus8) begin
      bus_oe_n[7:0] = ~spio[15:8];
    end
  end
  assign video_data_bus_oe_n = bus_oe_n;
  assign marker_oe_n = off || fmt[1];
  assign clock_oe_n = off || fmt[2];
  assign caption_fifo_half_full_n = 1'b0;
  assign caption_fifo_half_full_n_oe_n =
    !(caption_level >= 5'(CC_HALF) && !fmt[`VDOP_FMT_CCDIS]);

  // read side
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      s_axi_rdata <= '0;
      if (mapped(s_axi_araddr)) begin
        unique case (s_axi_araddr[4:2])
          `VDOP_A_TC: s_axi_rdata <= tc;
          `VDOP_A_POL: s_axi_rdata <= pol;
          `VDOP_A_FMT: s_axi_rdata <= fmt;
          `VDOP_A_HWIN: s_axi_rdata <= hwin;
          `VDOP_A_VWIN: s_axi_rdata <= vwin;
          `VDOP_A_GEOM: s_axi_rdata <= geom;
          `VDOP_A_SPIO: s_axi_rdata <= {8'h00, gpio_s, spio[15:0]};
          `VDOP_A_STAT: s_axi_rdata <= {27'h000_0000, xtal_s, tri_hold,
                                        power_down,
                                        !caption_fifo_half_full_n_oe_n, odd};
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  AST_LP_FALL: assert property ($fell(lp_raw) |->
    $past(lp_cnt) == 7'(LP_WIDTH - 1)) else $error("line pulse width");
  AST_LP_UNIT: assert property (adv && lp_raw &&
    tc[`VDOP_TC_UNIT] && !pix_ok && hcnt < geom[9:0] - 10'd1 |=>
    $stable(lp_cnt)) else $error("line pulse counted a non-pixel");
  AST_FP_EDGE: assert property ($changed(fp_raw) |->
    $past(tick1)) else $error("field pulse off 1x edge");
  AST_POL: assert property ($past(rst_b) |->
    mk == $past(raw ^ pol[6:0])) else $error("marker polarity");
  AST_QUALIFIED_PIXEL_CLOCK: assert property ($rose(qualified_pixel_clock) |->
    $past(valid_q)) else $error("qualified clock without pixel");
  AST_QUALIFIED_PIXEL_CLOCK_CODE: assert property ($rose(qualified_pixel_clock) |->
    !$past(code_q)) else $error("qualified clock during code");
  AST_OE: assert property (oe_s |-> marker_oe_n && clock_oe_n &&
    &video_data_bus_oe_n[15:8]) else $error("driven while disabled");
  AST_CC: assert property (caption_level >= 5'(CC_HALF) &&
    !fmt[`VDOP_FMT_CCDIS] |-> !caption_fifo_half_full_n_oe_n)
    else $error("caption status not pulled low");
  AST_PD: assert property (power_down |=> $stable(hcnt) &&
    $stable(vcnt)) else $error("raster moved in power-down");
  AST_PAR: assert property ($changed(odd) |-> vcnt == '0 &&
    $past(adv)) else $error("parity changed off field start");

  COV_LINE: cover property ($fell(lp_raw));
  COV_QCLK8: cover property (bus8 && $rose(qualified_pixel_clock));
  COV_CODE: cover property (mode2 && code_q ##1 !code_q);
  COV_WR: cover property (wr_fire ##[1:4] s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// ### sim/vdop_capture.sv
/*
 * Capture-side model of the pixel port: resolves bus lines, measures
 * marker runs and checks qualified clock edges against pixel valid.
 * Assumes markers are registered on sys_clk; polarity bits come from bench.
 */
`timescale 1ns/100ps
`default_nettype none
module vdop_capture (
  input wire logic sys_clk, // twice the 2x clock
  input wire logic rst_b, // reset, active low
  input wire logic [6:0] inv, // polarity bits in force
  input wire logic line_start_pulse, // line marker
  input wire logic field_start_pulse, // field marker
  input wire logic field_parity, // odd field marker
  input wire logic pixel_valid, // pixel marker
  input wire logic vertical_window, // blanking marker
  input wire logic qualified_pixel_clock, // gated clock
  input wire logic [15:0] video_data_bus, // bus out
  input wire logic [15:0] video_data_bus_oe_n, // low drives
  input wire logic spare_en, // bench drives lower lines
  input wire logic [7:0] spare_val, // bench level on lower lines
  output logic [15:0] bus_seen, // resolved line levels
  output int lp_run, // last line pulse run
  output int fp_run, // last field pulse run
  output int vw_run, // last window run
  output logic [1:0] par, // parity at last two field pulse falls
  output int qc_bad // qualified edges with no pixel
);
  logic lp, fp, vw, pv, pv_q, qc_q, fp_q;
  logic [6:0] inv_q;
  logic [15:0] last;
  int lp_c, fp_c, vw_c;
  assign lp = line_start_pulse ^ inv[0];
  assign fp = field_start_pulse ^ inv[1];
  assign pv = pixel_valid ^ inv[5];
  assign vw = ~(vertical_window ^ inv[6]);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!video_data_bus_oe_n[i]) bus_seen[i] = video_data_bus[i];
      else if (i < 8 && spare_en) bus_seen[i] = spare_val[i & 7];
      else bus_seen[i] = ~last[i]; // released line keeps no stale value
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {lp_c, fp_c, vw_c, lp_run, fp_run, vw_run, qc_bad} <= '0;
      {pv_q, qc_q, fp_q, par, inv_q, last} <= '0;
    end else begin
      last <= bus_seen;
      inv_q <= inv;
      lp_c <= lp ? lp_c + 1 : 0;
      fp_c <= fp ? fp_c + 1 : 0;
      vw_c <= vw ? vw_c + 1 : 0;
      if (!lp && lp_c > 0) lp_run <= lp_c;
      if (inv != inv_q) lp_run <= 0;
      if (!fp && fp_c > 0) fp_run <= fp_c;
      if (!vw && vw_c > 0) vw_run <= vw_c;
      fp_q <= fp;
      if (fp_q && !fp) par <= {par[0], field_parity ^ inv[3]};
      pv_q <= pv;
      qc_q <= qualified_pixel_clock;
      if (qualified_pixel_clock && !qc_q && !pv && !pv_q) qc_bad <= qc_bad + 1;
    end
  end
endmodule
`default_nettype wire

// ### sim/vdop_top_test.sv
/*
 * Self-checking bench of the video output port: register bus, pins,
 * markers and bus modes. Assumes vdop_top and vdop_capture are compiled.
 */
`timescale 1ns/100ps
`default_nettype none
module vdop_top_test;
  import vdop_pkg::*;
  localparam int LPW = 64;
  localparam int FPL = 6;
  localparam int CCH = 8;
  localparam int LINE = 400;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pix_luma, pix_chroma, spare_val;
  logic [31:0] s_axi_wdata, rdat, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, pix_ok, rnd, spare_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, par, seen;
  vdop_word_t s_axi_rdata;
  logic [4:0] caption_level;
  logic [4:0] lv [4] = '{5'h00, 5'h07, 5'h08, 5'h10};
  logic output_enable_n, power_down_input, tristate_at_reset_select;
  logic crystal_count_select, line_start_pulse, field_start_pulse, active;
  logic field_parity, chroma_phase_flag, pixel_valid, vertical_window;
  logic marker_oe_n, qualified_pixel_clock, pixel_clock_1x, pixel_clock_2x;
  logic clock_oe_n, caption_fifo_half_full_n_oe_n, power_down;
  logic crystal_default_secondary;
  logic [15:0] video_data_bus, video_data_bus_oe_n, bus_seen;
  logic [6:0] inv;
  int lp_run, fp_run, vw_run, qc_bad, bad_count, tests_run, seed;
  vdop_top #(.LP_WIDTH(LPW), .FP_LINES(FPL), .CC_HALF(CCH)) vdop_top_i (
    .sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pix_luma, .pix_chroma, .pix_ok, .caption_level,
    .output_enable_n, .power_down_input, .tristate_at_reset_select,
    .crystal_count_select, .line_start_pulse, .field_start_pulse, .active,
    .field_parity, .chroma_phase_flag, .pixel_valid, .vertical_window,
    .marker_oe_n, .qualified_pixel_clock, .pixel_clock_1x,
    .pixel_clock_2x, .clock_oe_n, .video_data_bus,
    .video_data_bus_in(bus_seen[7:0]), .video_data_bus_oe_n,
    .caption_fifo_half_full_n(), .caption_fifo_half_full_n_oe_n,
    .power_down, .crystal_default_secondary);
  vdop_capture vdop_capture_i (.sys_clk, .rst_b, .inv, .line_start_pulse,
    .field_start_pulse, .field_parity, .pixel_valid, .vertical_window,
    .qualified_pixel_clock, .video_data_bus, .video_data_bus_oe_n,
    .spare_en, .spare_val, .bus_seen, .lp_run, .fp_run, .vw_run, .par,
    .qc_bad);
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rnd) {pix_luma, pix_chroma, pix_ok} <= 17'($urandom);
  end
  function automatic logic cap_oe(input logic [4:0] l);
    return l < 5'(CCH);
  endfunction
  function automatic logic [17:0] grp(input int b);
    return {b == 0 ? 16'hFFFF : 16'h0000, b == 1, b == 2};
  endfunction
  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo(inout int n);
    n++;
    if (n > 300) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wt(input int k);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      tmo(n);
    end while (!(k == 2 ? s_axi_bvalid : k == 3 ? s_axi_arready
                 : s_axi_rvalid));
    rsp = k == 2 ? s_axi_bresp : s_axi_rresp;
    rdat = s_axi_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ka, kw;
    int n;
    pa = 1;
    pw = 1;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (pa || pw) begin
      @(negedge sys_clk);
      ka = pa && s_axi_awready;
      kw = pw && s_axi_wready;
      tmo(n);
      @(posedge sys_clk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      pa = pa && !ka;
      pw = pw && !kw;
    end
    wt(2);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    wt(3);
    s_axi_arvalid <= 1'b0;
    wt(4);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  initial begin
    seed = $urandom(90);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, pix_ok, rnd, spare_en, spare_val, inv} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pix_luma, pix_chroma} = '0;
    {caption_level, power_down_input, crystal_count_select} = '0;
    {tristate_at_reset_select, bad_count, tests_run} = '0;
    s_axi_wstrb = 4'hF;
    output_enable_n = 1'b1;
    cyc(5);
    rst_b <= 1'b1;
    cyc(4);
    chk(marker_oe_n, 1);
    rc(8'h0C, 32'h0340_0080);
    rc(8'h10, 32'h01E0_0028);
    rc(8'h14, 32'h020D_038E);
    rd(8'h20);
    chk(rsp, 2'b10);
    wr(8'h21, 32'h0000_0001);
    chk(rsp, 2'b10);
    v = $urandom & 32'h0000_007F;
    wr(8'h04, v);
    rc(8'h04, v);
    wr(8'h04, 32'h0000_0000);
    output_enable_n <= 1'b0;
    cyc(4);
    chk({marker_oe_n, clock_oe_n}, 0);
    wr(8'h14, 32'h0014_0064);
    wr(8'h10, 32'h0008_0008);
    rnd <= 1'b1;
    cyc(13000);
    chk(lp_run, 4 * LPW);
    chk(fp_run, FPL * LINE);
    chk(vw_run, 4 * LINE);
    chk(par[0] ^ par[1], 1);
    chk(qc_bad, 0);
    wr(8'h04, 32'h0000_0001);
    inv <= 7'h01;
    cyc(600);
    chk(lp_run, 4 * LPW);
    wr(8'h04, 32'h0000_0000);
    inv <= 7'h00;
    power_down_input <= 1'b1;
    cyc(4);
    chk(power_down, 1);
    power_down_input <= 1'b0;
    wr(8'h00, 32'h0000_0020);
    cyc(2);
    chk(power_down, 1);
    wr(8'h00, 32'h0000_0000);
    cyc(2);
    chk(power_down, 0);
    for (int i = 0; i < 2; i++) begin
      crystal_count_select <= i[0];
      cyc(4);
      chk(crystal_default_secondary, i);
    end
    foreach (lv[i]) begin
      caption_level <= lv[i];
      cyc(4);
      chk(caption_fifo_half_full_n_oe_n, cap_oe(lv[i]));
    end
    for (int b = 0; b < 4; b++) begin
      wr(8'h08, 32'(1 << b));
      cyc(2);
      if (b < 3)
        chk({video_data_bus_oe_n, marker_oe_n, clock_oe_n}, grp(b));
      else chk(caption_fifo_half_full_n_oe_n, 1);
    end
    wr(8'h08, 32'h0000_0000);
    rnd <= 1'b0;
    cyc(1);
    {pix_ok, pix_luma, pix_chroma} <= 17'h1_3CC3;
    cyc(8);
    chk(video_data_bus, 16'h3CC3);
    chk(qualified_pixel_clock, !pixel_clock_1x);
    wr(8'h00, 32'h0000_0004);
    seen = 2'b00;
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      seen |= {video_data_bus[15:8] === 8'h3C,
               video_data_bus[15:8] === 8'hC3};
    end
    chk(seen, 2'b11);
    chk(video_data_bus_oe_n[7:0], 8'hFF);
    wr(8'h18, 32'h0000_FFA5);
    cyc(2);
    chk({video_data_bus[7:0], video_data_bus_oe_n[7:0]}, 16'hA500);
    v = $urandom & 32'h0000_00FF;
    wr(8'h18, 32'h0000_0000);
    spare_val <= v[7:0];
    spare_en <= 1'b1;
    cyc(4);
    rd(8'h18);
    chk(rdat[23:16], v[7:0]);
    output_enable_n <= 1'b1;
    cyc(4);
    chk({video_data_bus_oe_n, marker_oe_n, clock_oe_n}, 18'h3_FFFF);
    {tristate_at_reset_select, output_enable_n, rst_b} <= 3'b100;
    cyc(5);
    rst_b <= 1'b1;
    cyc(8);
    chk(marker_oe_n, 1);
    wr(8'h00, 32'h0000_0040);
    cyc(2);
    chk(marker_oe_n, 0);
    end_sim();
  end
endmodule
`default_nettype wire
